// *** sim/fls_host_model.sv ***
// Purpose: host side that polls the status byte
// Assumes: strobe is taken at the next rising edge of clk_i
// Notes:   the byte is taken in the strobe cycle, before it clears
module fls_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] stat_i,
  output logic            stat_rd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // idle until a poll is asked for
  initial stat_rd_o = 1'b0;
  // one poll; the read itself clears the latched flags
  task automatic read_status(output logic [7:0] v);
    stat_rd_o = 1'b1;
    v         = stat_i;
    @(posedge clk_i);
    #2 stat_rd_o = 1'b0;
  endtask : read_status
endmodule : fls_host_model

// *** sim/fls_status_top_properties.sv ***
// Purpose: port-level checks of the status and alert logic
// Assumes: one clock, synchronous active-high reset
// Notes:   comparator sync latency is two cycles
module fls_status_props #(
  parameter int unsigned PRECHARGE_CYCLES = fls_pkg::PRECHARGE_CYC
) (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       stat_rd_i,
  input wire logic [7:0] stat_o,
  input wire logic       power_up_request_i,
  input wire logic       soft_trigger_gate_i,
  input wire logic [3:0] torch_dim_i,
  input wire logic [3:0] flash_dim_i,
  input wire logic       flash_timeout_i,
  input wire logic       led_warn_cmp_i,
  input wire logic [4:0] current_step_o,
  input wire logic       flash_active_o,
  input wire logic       force_ready_o,
  input wire logic       precharge_o,
  input wire logic       converter_en_o,
  input wire logic       alert_n_o
);
  import fls_pkg::*;
  // ==========================================================
  // all checks share the one clock and its reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ladder mapping, flash has priority over torch
  chk_flash_step: assert property (flash_active_o |->
    current_step_o == 5'($past(flash_dim_i)) + FLASH_BASE)
    else $error("flash step off the ladder");
  chk_torch_step: assert property (
    current_step_o != 5'h00 && !flash_active_o |->
    current_step_o == 5'($past(torch_dim_i)) + TORCH_BASE)
    else $error("torch step off the ladder");
  chk_flash_gate: assert property (flash_active_o |->
    $past(soft_trigger_gate_i) && $past(power_up_request_i))
    else $error("flash without gate or power");
  // live flag: without gate or power the bit must drop at the next edge
  chk_frun_bit: assert property (
    !(soft_trigger_gate_i && power_up_request_i) |=> !stat_o[B_FRUN])
    else $error("flash bit stuck high");
  // latched flags and the alert line
  chk_flag_alert: assert property (|stat_o[5:2] |-> !alert_n_o)
    else $error("flag set with alert high");
  chk_alert_release: assert property ($rose(alert_n_o) |->
    stat_o[5:2] == 4'h0) else $error("alert released early");
  chk_timeout_alert: assert property (flash_timeout_i &&
    power_up_request_i |=> !alert_n_o) else $error("no timeout alert");
  chk_read_clears: assert property (
    stat_rd_i && !led_warn_cmp_i && !$past(led_warn_cmp_i) &&
    !$past(led_warn_cmp_i, 2) && !$past(led_warn_cmp_i, 3)
    |=> !stat_o[B_WARN]) else $error("warning survived a read");
  // forcing to ready mode stops the LED
  chk_force_cause: assert property (force_ready_o |->
    (stat_o[5] | stat_o[3] | stat_o[2] | stat_o[0]))
    else $error("force without forcing flag");
  chk_force_off: assert property (force_ready_o |->
    current_step_o == STEP_OFF && !flash_active_o)
    else $error("LED on while forced");
  // start-up check of the output
  chk_pre_pending: assert property (
    precharge_o |-> stat_o[B_SHORT]) else $error("pending low in window");
  chk_run_clear: assert property (
    converter_en_o |-> !stat_o[B_SHORT])
    else $error("pending high while running");
  chk_short_stop: assert property (
    $fell(precharge_o) && !converter_en_o && power_up_request_i |->
    !alert_n_o && stat_o[B_SHORT]) else $error("short not flagged");
endmodule : fls_status_props

bind fls_status_top fls_status_props #(
  .PRECHARGE_CYCLES(PRECHARGE_CYCLES)
) i_props (.*);

// *** sim/tb_flash_led_status_faults.sv ***
// Purpose: self-checking bench of the status and alert logic
// Assumes: short precharge window to keep the run brief
// Notes:   inputs change 2 ns after each rising edge
module tb_flash_led_status_faults;
  timeunit 1ns;
  timeprecision 100ps;
  import fls_pkg::*;
  localparam int PRE = 20;
  logic       clk_i, sys_rst_i, stat_rd_i, power_up_request_i;
  logic       soft_trigger_gate_i, torch_on_i, flash_timeout_i;
  logic       trigger_pin_i, ovp_i, led_warn_cmp_i, led_high_cmp_i;
  logic       die_ot_cmp_i, vout_ok_cmp_i, flash_active_o;
  logic       force_ready_o, precharge_o, converter_en_o, alert_n_o;
  logic [3:0] torch_dim_i, flash_dim_i;
  logic [4:0] current_step_o;
  logic [7:0] stat_o, v;
  int         failures, check_count;
  logic [7:0] exp_q[$] = '{8'h20, 8'h10, 8'h08, 8'h04};

  fls_status_top #(.PRECHARGE_CYCLES(PRE)) i_dut (.*);
  fls_host_model i_host (.clk_i(clk_i), .stat_i(stat_o),
                         .stat_rd_o(stat_rd_i));
  // ==========================================================
  // 50 MHz clock
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : cyc
  function automatic int ladder(input bit fl, input int code);
    return fl ? code + 9 : code + 1;
  endfunction : ladder
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    print_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(37238));
    {power_up_request_i, soft_trigger_gate_i, torch_on_i} = 3'h0;
    {flash_timeout_i, trigger_pin_i, ovp_i, led_warn_cmp_i} = 4'h0;
    {led_high_cmp_i, die_ot_cmp_i, vout_ok_cmp_i} = 3'h0;
    {torch_dim_i, flash_dim_i} = 8'h00;
    sys_rst_i = 1'b1;
    cyc(20);
    sys_rst_i = 1'b0;
    chk("reset stat", STAT_RESET, stat_o);
    chk("reset alert", 8'h01, {7'h0, alert_n_o});
    power_up_request_i = 1'b1;
    cyc(2);
    chk("pending", 8'h01, stat_o);
    chk("precharge", 8'h01, 8'(precharge_o));
    vout_ok_cmp_i = 1'b1;
    cyc(4);
    chk("running", 8'h01, {7'h0, converter_en_o});
    chk("pending clr", 8'h00, stat_o);
    $display("test start-up done");
    torch_on_i = 1'b1;
    for (int i = 0; i < 16; i++) begin
      torch_dim_i = 4'(i);
      cyc(2);
      chk("torch step", 8'(ladder(0, i)), {3'h0, current_step_o});
    end
    {soft_trigger_gate_i, trigger_pin_i} = 2'b11;
    cyc(4);
    chk("flash bit", 8'h40, stat_o);
    chk("flash act", 8'h01, 8'(flash_active_o));
    for (int i = 0; i < 16; i++) begin
      flash_dim_i = 4'(i);
      torch_dim_i = 4'($urandom_range(15));
      cyc(2);
      chk("flash step", 8'(ladder(1, i)), {3'h0, current_step_o});
    end
    trigger_pin_i = 1'b0;
    cyc(4);
    i_host.read_status(v);
    chk("flash end", 8'h00, v);
    chk("flash off", 8'h00, 8'(flash_active_o));
    soft_trigger_gate_i = 1'b0;
    $display("test ladder done");
    // a short spike on the open-LED comparator must be ignored
    ovp_i = 1'b1;
    cyc(5);
    ovp_i = 1'b0;
    cyc(4);
    chk("glitch", 8'h00, stat_o);
    for (int k = 0; k < 4; k++) begin
      {ovp_i, led_warn_cmp_i, led_high_cmp_i, die_ot_cmp_i} = 4'h8 >> k;
      cyc(16);
      chk("flag", exp_q[k], stat_o);
      chk("alert", 8'h00, {7'h0, alert_n_o});
      chk("force", 8'(k != 1), {7'h0, force_ready_o});
      if (k == 1) begin
        chk("keep", 8'(ladder(0, torch_dim_i)), 8'(current_step_o));
      end
      {ovp_i, led_warn_cmp_i, led_high_cmp_i, die_ot_cmp_i} = 4'h0;
      cyc(4);
      i_host.read_status(v);
      chk("read", exp_q[k], v);
      chk("cleared", 8'h00, stat_o);
      chk("release", 8'h01, {7'h0, alert_n_o});
    end
    $display("test faults done");
    flash_timeout_i = 1'b1;
    cyc(1);
    flash_timeout_i = 1'b0;
    chk("timeout", 8'h00, {7'h0, alert_n_o});
    i_host.read_status(v);
    chk("to release", 8'h01, {7'h0, alert_n_o});
    $display("test timeout done");
    {power_up_request_i, vout_ok_cmp_i} = 2'b00;
    cyc(2);
    power_up_request_i = 1'b1;
    cyc(PRE + 8);
    chk("short", 8'h01, stat_o);
    chk("no start", 8'h00, {7'h0, converter_en_o});
    chk("sh alert", 8'h00, {7'h0, alert_n_o});
    $display("test short done");
    print_verdict();
  end
endmodule : tb_flash_led_status_faults

// *** verilog/fls_filt_if.sv ***
// Purpose: carrier between the top and the open-LED glitch filter
// Assumes: raw comes straight from an asynchronous comparator
// Notes:   clean is a registered level on clk_i
interface fls_filt_if;
  logic raw;
  logic clean;

  modport filt (
    input  raw,
    output clean
  );
  modport user (
    output raw,
    input  clean
  );
endinterface : fls_filt_if

// *** verilog/fls_glitch_filter.sv ***
// Purpose: synchronise and deglitch the output overvoltage comparator
// Assumes: one clock, synchronous reset
// Notes:   clean rises only after FILT_CYC + 1 consecutive high samples
module fls_glitch_filter (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  fls_filt_if.filt  fif
);
  import fls_pkg::*;

  typedef struct packed {
    logic              s1;
    logic              s2;
    logic [FILT_W-1:0] cnt;
    logic              clean;
  } fls_filt_st_t;

  localparam logic [FILT_W-1:0] CNT_LAST = FILT_W'(FILT_CYC);
  localparam fls_filt_st_t      RST      = '0;

  fls_filt_st_t q;
  fls_filt_st_t d;

  // ==========================================================
  // two-flop sync, then a run-length counter; any low sample restarts
  // it, so ringing shorter than the window never reaches the flag
  always_comb begin
    d    = q;
    d.s1 = fif.raw;
    d.s2 = q.s1;
    if (!q.s2) begin
      d.cnt = '0;
    end else if (q.cnt != CNT_LAST) begin
      d.cnt = q.cnt + 1'b1;
    end
    d.clean = q.s2 && (q.cnt == CNT_LAST);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign fif.clean = q.clean;

endmodule : fls_glitch_filter

// *** verilog/fls_pkg.sv ***
// Purpose: shared constants and types of the flash-LED status logic
// Assumes: 50 MHz clk_i, synchronous active-high reset
// Notes:   status byte is read through a plain strobe from the serial port
package fls_pkg;

  // ==========================================================
  // status register
  localparam logic [7:0] STAT_ADDR  = 8'h03;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam int B_FRUN  = 6;
  localparam int B_OPEN  = 5;
  localparam int B_WARN  = 4;
  localparam int B_HIGH  = 3;
  localparam int B_DIEOT = 2;
  localparam int B_SHORT = 0;

  // ==========================================================
  // current ladder
  localparam int          STEP_W     = 5;
  localparam int          DIM_W      = 4;
  localparam logic [4:0]  TORCH_BASE = 5'h01;
  localparam logic [4:0]  FLASH_BASE = 5'h09;
  localparam logic [4:0]  STEP_OFF   = 5'h00;

  // ==========================================================
  // timing
  localparam int CLK_MHZ       = 50;
  localparam int PRECHARGE_US  = 360;
  localparam int PRECHARGE_CYC = PRECHARGE_US * CLK_MHZ;
  localparam int PC_W          = 15;
  localparam int FILT_NS       = 200;
  localparam int FILT_CYC      = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W        = 4;

  // ==========================================================
  // synchronised trigger pin and comparator inputs, index into one vector
  localparam int SI_TRIGGER_PIN  = 0;
  localparam int SI_WARN  = 1;
  localparam int SI_HIGH  = 2;
  localparam int SI_DIEOT = 3;
  localparam int SI_VOK   = 4;
  localparam int N_SYNC   = 5;

  // start-up sequence of the converter
  typedef enum logic [1:0] {
    S_OFF,
    S_PRE,
    S_RUN,
    S_SHORT
  } fls_state_t;

endpackage : fls_pkg

// *** verilog/fls_status_top.sv ***
// Purpose: fault/status flags, alert line and current ladder mapping
// Assumes: command bits arrive from the register file on clk_i
// Notes:   comparator and trigger pins are asynchronous and synchronised
module fls_status_top #(
  parameter int unsigned PRECHARGE_CYCLES = fls_pkg::PRECHARGE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  // status register read port
  input  wire logic                      stat_rd_i,
  output logic [7:0]                     stat_o,
  // command and dimming bits
  input  wire logic                      power_up_request_i,
  input  wire logic                      soft_trigger_gate_i,
  input  wire logic                      torch_on_i,
  input  wire logic [fls_pkg::DIM_W-1:0] torch_dim_i,
  input  wire logic [fls_pkg::DIM_W-1:0] flash_dim_i,
  input  wire logic                      flash_timeout_i,
  // asynchronous pins and comparators
  input  wire logic                      trigger_pin_i,
  input  wire logic                      ovp_i,
  input  wire logic                      led_warn_cmp_i,
  input  wire logic                      led_high_cmp_i,
  input  wire logic                      die_ot_cmp_i,
  input  wire logic                      vout_ok_cmp_i,
  // outputs
  output logic [fls_pkg::STEP_W-1:0]     current_step_o,
  output logic                           flash_active_o,
  output logic                           force_ready_o,
  output logic                           precharge_o,
  output logic                           converter_en_o,
  output logic                           alert_n_o
);
  import fls_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    fls_state_t        state;
    logic [PC_W-1:0]   pc_cnt;
    logic [N_SYNC-1:0] sync1;
    logic [N_SYNC-1:0] sync2;
    logic              flash_run;
    logic              open_led;
    logic              led_warn;
    logic              led_high;
    logic              die_ot;
    logic              short_pend;
    logic              tmo_pend;
    logic              force_ready;
    logic              alert_n;
    logic [STEP_W-1:0] step;
  } fls_top_st_t;

  localparam logic [PC_W-1:0] PC_LAST = PC_W'(PRECHARGE_CYCLES - 1);
  localparam fls_top_st_t RST = '{
    state:   S_OFF,
    alert_n: 1'b1,
    step:    STEP_OFF,
    default: '0
  };

  fls_top_st_t       q;
  fls_top_st_t       d;
  logic [N_SYNC-1:0] async_vec;
  logic              powered;
  logic              vok;
  logic              flash_act;
  logic              torch_act;
  logic              ev_start;
  logic              ev_vok;
  logic              ev_to;
  logic              ev_open;
  logic              ev_warn;
  logic              ev_high;
  logic              ev_dieot;
  logic              forcing;
  logic              rd;

  fls_filt_if ovp_if ();

  // ==========================================================
  // open-LED comparator goes through its own deglitcher
  assign ovp_if.raw = ovp_i;

  fls_glitch_filter u_ovp_filt (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .fif       (ovp_if.filt)
  );

  // gather the asynchronous pins into one vector for the sync stage
  assign async_vec[SI_TRIGGER_PIN]  = trigger_pin_i;
  assign async_vec[SI_WARN]  = led_warn_cmp_i;
  assign async_vec[SI_HIGH]  = led_high_cmp_i;
  assign async_vec[SI_DIEOT] = die_ot_cmp_i;
  assign async_vec[SI_VOK]   = vout_ok_cmp_i;

  // ==========================================================
  // event decode, all from second sync stage, the open-LED filter output or same-clock inputs
  always_comb begin
    powered   = power_up_request_i;
    rd        = stat_rd_i;
    vok       = q.sync2[SI_VOK];
    // converter may only run after a good start-up check
    flash_act = soft_trigger_gate_i && q.sync2[SI_TRIGGER_PIN] && powered
                && (q.state == S_RUN);
    torch_act = torch_on_i && powered && (q.state == S_RUN)
                && !flash_act;
    ev_start  = powered && (q.state == S_OFF);
    ev_vok    = powered && (q.state == S_PRE) && vok;
    ev_to     = powered && (q.state == S_PRE) && !vok
                && (q.pc_cnt == PC_LAST);
    ev_open   = ovp_if.clean && (flash_act || torch_act);
    ev_warn   = powered && q.sync2[SI_WARN];
    ev_high   = powered && q.sync2[SI_HIGH];
    ev_dieot  = powered && q.sync2[SI_DIEOT];
    // warning alone never forces ready mode
    forcing   = ev_open || ev_high || ev_dieot || ev_to;
  end

  // ==========================================================
  // next state
  always_comb begin
    d       = q;
    d.sync1 = async_vec;
    d.sync2 = q.sync1;

    // start-up sequence; a short leaves us parked until power drops
    case (q.state)
      S_OFF: begin
        if (powered) begin
          d.state  = S_PRE;
          d.pc_cnt = '0;
        end
      end
      S_PRE: begin
        if (!powered) begin
          d.state = S_OFF;
        end else if (vok) begin
          d.state = S_RUN;
        end else if (q.pc_cnt == PC_LAST) begin
          d.state = S_SHORT;
        end else begin
          d.pc_cnt = q.pc_cnt + 1'b1;
        end
      end
      S_RUN: begin
        if (!powered) begin
          d.state = S_OFF;
        end
      end
      S_SHORT: begin
        if (!powered) begin
          d.state = S_OFF;
        end
      end
      default: begin
        d.state = S_OFF;
      end
    endcase

    // latched flags: a set in the read cycle wins over the clear
    d.open_led = ev_open  || (q.open_led && !rd);
    d.led_warn = ev_warn  || (q.led_warn && !rd);
    d.led_high = ev_high  || (q.led_high && !rd);
    d.die_ot   = ev_dieot || (q.die_ot   && !rd);
    d.tmo_pend = flash_timeout_i || (q.tmo_pend && !rd);
    if (ev_vok) begin
      d.short_pend = 1'b0;
    end else begin
      d.short_pend = ev_start || ev_to || (q.state == S_PRE)
                     || (q.short_pend && !rd);
    end

    // shutdown wipes the status byte back to its reset value
    if (!powered) begin
      d.open_led   = 1'b0;
      d.led_warn   = 1'b0;
      d.led_high   = 1'b0;
      d.die_ot     = 1'b0;
      d.short_pend = 1'b0;
      d.tmo_pend   = 1'b0;
    end

    // live flag, no latch: host polls it to see flash end
    d.flash_run   = flash_act && !forcing;
    // level to the mode logic, high while any forcing event lasts; power-up bit itself is untouched
    d.force_ready = forcing;

    // pending only alerts once the window is missed, not during it
    d.alert_n = !(d.open_led || d.led_warn || d.led_high || d.die_ot
                  || (d.short_pend && (d.state == S_SHORT))
                  || d.tmo_pend);

    // ladder: torch codes 1 to 16 and flash codes 9 to 24 share one scale
    if (forcing) begin
      d.step = STEP_OFF;
    end else if (flash_act) begin
      d.step = STEP_W'(flash_dim_i) + FLASH_BASE;
    end else if (torch_act) begin
      d.step = STEP_W'(torch_dim_i) + TORCH_BASE;
    end else begin
      d.step = STEP_OFF;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // status byte; unused bits read as zero
  always_comb begin
    stat_o          = STAT_RESET;
    stat_o[B_FRUN]  = q.flash_run;
    stat_o[B_OPEN]  = q.open_led;
    stat_o[B_WARN]  = q.led_warn;
    stat_o[B_HIGH]  = q.led_high;
    stat_o[B_DIEOT] = q.die_ot;
    stat_o[B_SHORT] = q.short_pend;
  end

  // outputs
  assign current_step_o = q.step;
  assign flash_active_o = q.flash_run;
  assign force_ready_o  = q.force_ready;
  assign precharge_o    = (q.state == S_PRE);
  assign converter_en_o = (q.state == S_RUN);
  assign alert_n_o      = q.alert_n;

endmodule : fls_status_top
